// ---- reset_and_powerup_sequencer.sv ----
// Reset cause tracking, power-up and oscillator start-up timing, clock-out divider.
// Assumes rst_n is the analog power-on pulse and that fuses are static after it.
// Functional notes
// - Distinguish power-on, pin run, pin sleep, watchdog reset, watchdog wake, brown-out.
// - One register class is never reset; it keeps contents across all resets.
// - Defined-value registers reset on power-on, pin, watchdog and brown-out resets.
// - Watchdog wake-up from sleep leaves defined-value registers untouched.
// - Timeout and power-down flags are set or cleared per reset cause.
// - Reset pin is filtered; pulses shorter than the minimum width are ignored.
// - Power-on reset happens only on a rising supply, never on decline.
// - Power-up timer runs only after power-on or brown-out reset.
// - Power-up timer counts a dedicated RC oscillator, not the main clock.
// - Core stays in reset while the power-up timer counts.
// - Power-up timer disable fuse: one disables unless brown-out is enabled, zero enables.
// - Crystal modes accept a crystal or an external clock on the input pin.
// - RC mode drives oscillator divided by four on the clock-out pin.
// - Start-up timer holds reset for 1024 input-oscillator cycles after power-up timer.
// - Start-up timer runs only in crystal modes, after power-on, brown-out or watchdog wake.
// - Power-up timer starts after the power-on pulse, start-up timer follows.
// - Power-on reset sets both the timeout and power-down flags.
`timescale 1ns/1ns
module reset_and_powerup_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned POWER_UP_TIMER_TICKS = reset_seq_pkg::POWER_UP_TIMER_RC_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_reset_pin_n,
    input wire logic brownout_det,
    input wire logic rc_osc_pin,
    input wire logic osc_in_pin,
    input wire reset_seq_pkg::cfg_t cfg,
    input wire logic watchdog_timeout,
    input wire logic core_sleeping,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic core_hold,
    output logic defined_reset,
    output logic wake_pulse,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic osc_out_clock_out_pin,
    output logic osc_out_clock_out_pin_oe,
    output logic irq
);
    import reset_seq_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_SRC_HOLD, ST_POWER_UP_TIMER, ST_OST} state_t;

    localparam logic [21:0] POWER_UP_TIMER_LAST = 22'(POWER_UP_TIMER_TICKS - 1);
    localparam logic [21:0] OST_LAST = 22'(OST_CYCLES - 1);

    function automatic logic is_crystal(input logic [1:0] mode);
        is_crystal = (mode != OSC_RC);
    endfunction : is_crystal

    state_t state_r;
    state_t state_nxt;
    logic [2:0] cause_r;
    logic [2:0] cause_nxt;
    flags_t flags_r;
    flags_t flags_nxt;
    logic [21:0] tmr_r;
    logic [21:0] tmr_nxt;
    logic [7:0] irq_status_r;
    logic [7:0] irq_status_nxt;
    logic [7:0] irq_mask_r;
    logic [7:0] irq_mask_nxt;
    logic [7:0] scratch_r;
    logic [7:0] rdata_nxt;
    logic [1:0] div_r;
    logic pin_low_d_r;
    logic osc_d_r;
    logic rc_d_r;
    logic ev_valid;
    logic [2:0] ev_cause;
    logic pin_s;
    logic bor_s;
    logic osc_s;
    logic rc_s;

    // Pin-side inputs; the reset pin and brown-out detector are width filtered
    sync_filter #(.MIN_CYCLES(EXT_RESET_PIN_N_MIN_CYCLES), .RST_VAL(1'b1)) u_pin (
        .clk(clk), .rst_n(rst_n), .raw(ext_reset_pin_n), .level(pin_s));
    sync_filter #(.MIN_CYCLES(BOR_MIN_CYCLES), .RST_VAL(1'b0)) u_bor (
        .clk(clk), .rst_n(rst_n), .raw(brownout_det), .level(bor_s));
    sync_filter #(.MIN_CYCLES(1), .RST_VAL(1'b0)) u_osc (
        .clk(clk), .rst_n(rst_n), .raw(osc_in_pin), .level(osc_s));
    sync_filter #(.MIN_CYCLES(1), .RST_VAL(1'b0)) u_rc (
        .clk(clk), .rst_n(rst_n), .raw(rc_osc_pin), .level(rc_s));

    // Source levels and edges
    wire pin_active = !pin_s;
    wire pin_fall = pin_active && !pin_low_d_r;
    wire bor_active = cfg.bor_enable && bor_s;
    wire osc_rise = osc_s && !osc_d_r;
    wire rc_rise = rc_s && !rc_d_r;
    wire rc_mode = !is_crystal(cfg.osc_mode);

    // Timer needs; brown-out enable forces the power-up timer on
    wire power_up_timer_on = !cfg.power_up_timer_disable || cfg.bor_enable;
    wire after_supply = (cause_r == CAUSE_POR) || (cause_r == CAUSE_BOR);
    wire ost_on = is_crystal(cfg.osc_mode) && (after_supply || cause_r == CAUSE_WDT_WAKE);
    wire power_up_timer_done = rc_rise && (tmr_r == POWER_UP_TIMER_LAST);
    wire ost_done = osc_rise && (tmr_r == OST_LAST);
    wire wdt_run = (state_r == ST_RUN) && watchdog_timeout;

    // Sequencer; brown-out wins over everything and re-initialises the timers
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        ev_valid = 1'b0;
        ev_cause = cause_r;
        case (state_r)
            ST_RUN: begin
                if (pin_fall) begin
                    ev_valid = 1'b1;
                    ev_cause = core_sleeping ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
                end else if (wdt_run && core_sleeping) begin
                    ev_valid = 1'b1;
                    ev_cause = CAUSE_WDT_WAKE;
                    if (is_crystal(cfg.osc_mode)) begin
                        state_nxt = ST_OST;
                    end
                end else if (wdt_run) begin
                    ev_valid = 1'b1;
                    ev_cause = CAUSE_WDT_RST;
                    state_nxt = ST_SRC_HOLD;
                end
            end
            ST_SRC_HOLD: begin
                if (!bor_active) begin
                    if (after_supply && power_up_timer_on) begin
                        state_nxt = ST_POWER_UP_TIMER;
                    end else if (ost_on) begin
                        state_nxt = ST_OST;
                    end else begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_POWER_UP_TIMER: begin
                if (power_up_timer_done) begin
                    state_nxt = ost_on ? ST_OST : ST_RUN;
                end
            end
            ST_OST: begin
                if (ost_done) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_SRC_HOLD;
        endcase
        if (bor_active && !(state_r == ST_SRC_HOLD && cause_r == CAUSE_BOR)) begin
            ev_valid = 1'b1;
            ev_cause = CAUSE_BOR;
            state_nxt = ST_SRC_HOLD;
        end
        if (ev_valid) begin
            cause_nxt = ev_cause;
        end
    end

    // Cause flags; brown-out and pin-in-run leave both flags as they were
    always_comb begin
        flags_nxt = flags_r;
        if (ev_valid) begin
            case (ev_cause)
                CAUSE_PIN_SLEEP: flags_nxt = '{timeout: 1'b1, powerdown: 1'b0};
                CAUSE_WDT_RST: flags_nxt.timeout = 1'b0;
                CAUSE_WDT_WAKE: flags_nxt = '{timeout: 1'b0, powerdown: 1'b0};
                default: flags_nxt = flags_r;
            endcase
        end
    end

    // One timer shared by both delays, cleared on every state change
    wire tmr_tick = ((state_r == ST_POWER_UP_TIMER) && rc_rise) || ((state_r == ST_OST) && osc_rise);
    assign tmr_nxt = (state_nxt != state_r) ? 22'h000000 : (tmr_tick ? tmr_r + 22'h000001 : tmr_r);

    // Internal reset is the OR of live sources and running timers
    wire hold_nxt = (state_nxt != ST_RUN) || pin_active || bor_active;
    wire defined_nxt = hold_nxt && (cause_nxt != CAUSE_WDT_WAKE);
    wire wake_nxt = (state_r != ST_RUN) && (state_nxt == ST_RUN) && (cause_r == CAUSE_WDT_WAKE);

    // Register decode
    wire wr_status = wr && (addr == ADDR_IRQ_STATUS);
    wire wr_mask = wr && (addr == ADDR_IRQ_MASK);
    wire wr_scratch = wr && (addr == ADDR_SCRATCH);
    wire [7:0] ev_bits = ev_valid ? (8'h01 << ev_cause) : 8'h00;
    wire [7:0] flags_word = {3'h0, flags_r.timeout, flags_r.powerdown, cause_r};

    // Set beats a same-cycle write-one clear
    assign irq_status_nxt = (irq_status_r & ~(wr_status ? wdata : 8'h00)) | ev_bits;
    // Mask is a defined-value register; watchdog wake keeps it
    assign irq_mask_nxt = defined_reset ? IRQ_MASK_RST : (wr_mask ? wdata : irq_mask_r);

    // Read mux; unmapped offsets read zero
    always_comb begin
        if (!rd) begin
            rdata_nxt = 8'h00;
        end else if (addr == ADDR_FLAGS) begin
            rdata_nxt = flags_word;
        end else if (addr == ADDR_IRQ_STATUS) begin
            rdata_nxt = irq_status_r;
        end else if (addr == ADDR_IRQ_MASK) begin
            rdata_nxt = irq_mask_r;
        end else if (addr == ADDR_SCRATCH) begin
            rdata_nxt = scratch_r;
        end else if (addr == ADDR_CONFIG) begin
            rdata_nxt = {4'h0, cfg};
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // Retained scratch; no reset of any kind, so power-up content is undefined
    always_ff @(posedge clk) begin
        if (wr_scratch) begin
            scratch_r <= wdata;
        end
    end

    // Power-on state: only the release of the analog pulse yields this cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_SRC_HOLD;
            cause_r <= CAUSE_POR;
            flags_r <= '{timeout: 1'b1, powerdown: 1'b1};
            tmr_r <= 22'h000000;
        end else begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            flags_r <= flags_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // Registered outputs and edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_hold <= 1'b1;
            defined_reset <= 1'b1;
            wake_pulse <= 1'b0;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
            irq_status_r <= IRQ_STATUS_RST;
            irq_mask_r <= IRQ_MASK_RST;
            irq <= 1'b0;
            rdata <= 8'h00;
            pin_low_d_r <= 1'b0;
            osc_d_r <= 1'b0;
            rc_d_r <= 1'b0;
        end else begin
            core_hold <= hold_nxt;
            defined_reset <= defined_nxt;
            wake_pulse <= wake_nxt;
            timeout_flag <= flags_nxt.timeout;
            powerdown_flag <= flags_nxt.powerdown;
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq <= |(irq_status_nxt & irq_mask_nxt);
            rdata <= rdata_nxt;
            pin_low_d_r <= pin_active;
            osc_d_r <= osc_s;
            rc_d_r <= rc_s;
        end
    end

    // Clock-out divider; a crystal drives the out pin in the other modes, so release it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 2'h0;
            osc_out_clock_out_pin <= 1'b0;
            osc_out_clock_out_pin_oe <= 1'b0;
        end else begin
            div_r <= osc_rise ? div_r + 2'h1 : div_r;
            osc_out_clock_out_pin <= rc_mode && div_r[1];
            osc_out_clock_out_pin_oe <= rc_mode;
        end
    end

    property p_power_up_timer_hold;
        @(posedge clk) disable iff (!rst_n) (state_r == ST_POWER_UP_TIMER) |-> core_hold;
    endproperty
    a_power_up_timer_hold: assert property (p_power_up_timer_hold) else $error("core released during power-up timer");

    property p_wake_keeps;
        @(posedge clk) disable iff (!rst_n)
            (wdt_run && core_sleeping && !pin_fall && !bor_active) |=> !defined_reset && !timeout_flag;
    endproperty
    a_wake_keeps: assert property (p_wake_keeps) else $error("watchdog wake reset registers");

    property p_wdt_flags;
        @(posedge clk) disable iff (!rst_n)
            (wdt_run && !core_sleeping && !pin_fall && !bor_active) |=> !timeout_flag && defined_reset;
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog reset flags wrong");

    property p_por_flags;
        @(posedge clk) disable iff (!rst_n)
            (cause_r == CAUSE_POR) |-> (flags_r.timeout && flags_r.powerdown);
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags not both set");

    property p_pin_no_timer;
        @(posedge clk) disable iff (!rst_n)
            (state_r == ST_RUN && pin_fall && !bor_active) |=> (state_r == ST_RUN);
    endproperty
    a_pin_no_timer: assert property (p_pin_no_timer) else $error("pin reset started a timer");

    property p_ost_end;
        @(posedge clk) disable iff (!rst_n)
            (state_r == ST_OST && ost_done && !bor_active) |=> (state_r == ST_RUN) ##1 !core_hold || pin_active;
    endproperty
    a_ost_end: assert property (p_ost_end) else $error("start-up timer length wrong");

    property p_rc_no_ost;
        @(posedge clk) disable iff (!rst_n) rc_mode |=> (state_r != ST_OST) || $past(!rc_mode);
    endproperty
    a_rc_no_ost: assert property (p_rc_no_ost) else $error("start-up timer ran in RC mode");

    property p_bor_hold;
        @(posedge clk) disable iff (!rst_n) bor_active |=> (state_r == ST_SRC_HOLD) ##1 core_hold;
    endproperty
    a_bor_hold: assert property (p_bor_hold) else $error("brown-out did not hold reset");

    property p_power_up_timer_skip;
        @(posedge clk) disable iff (!rst_n)
            (state_r == ST_SRC_HOLD && !bor_active && !power_up_timer_on) |=> (state_r != ST_POWER_UP_TIMER);
    endproperty
    a_power_up_timer_skip: assert property (p_power_up_timer_skip) else $error("disabled power-up timer ran");
endmodule : reset_and_powerup_sequencer

// ---- reset_and_powerup_sequencer_tb.sv ----
// Self-checking bench for the reset and power-up sequencer.
// Assumes the model supplies pin, detector and oscillators; POWER_UP_TIMER_TICKS shortened to 4.
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; $display("BAD %0t: got %h want %h", $time, (a), (e)); end end
module reset_and_powerup_sequencer_tb;
    import reset_seq_pkg::*;
    logic clk, rst_n, wdt, slp, wr, rd, prev;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    cfg_t cfg;
    logic pin_n, bo, rc, osc, hold, defr, wake, tof, pdf, cko, cko_oe, irq;
    int err_count, total_checks, cyc, k;

    reset_and_powerup_sequencer #(.POWER_UP_TIMER_TICKS(4)) reset_and_powerup_sequencer_i (
        .clk(clk), .rst_n(rst_n), .ext_reset_pin_n(pin_n), .brownout_det(bo), .rc_osc_pin(rc),
        .osc_in_pin(osc), .cfg(cfg), .watchdog_timeout(wdt), .core_sleeping(slp), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_hold(hold), .defined_reset(defr),
        .wake_pulse(wake), .timeout_flag(tof), .powerdown_flag(pdf), .osc_out_clock_out_pin(cko),
        .osc_out_clock_out_pin_oe(cko_oe), .irq(irq));
    supply_osc_model supply_osc_model_i (
        .clk(clk), .ext_reset_pin_n(pin_n), .brownout_det(bo), .rc_osc_pin(rc), .osc_in_pin(osc));

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, well above the roughly 23000 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            $display("BAD %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : chk_reg
    // Cycles until the core runs again must fall in [lo, hi]
    task automatic wait_hold(input int lo, input int hi);
        int n;
        n = 0;
        while (hold !== 1'b0 && n < 9000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask : wait_hold
    // Power-on pulse of 16 cycles with new fuses, then the timed release
    task automatic por(input cfg_t c, input int lo, input int hi);
        @(posedge clk);
        rst_n <= 1'b0;
        cfg <= c;
        repeat (16) @(posedge clk);
        `CHK({tof, pdf, hold}, 3'b111)
        rst_n <= 1'b1;
        wait_hold(lo, hi);
    endtask : por
    // Watchdog event; flags and holds are checked one cycle later
    task automatic wdt_evt(input logic s, input logic [1:0] fl, input logic dr);
        @(posedge clk);
        wdt <= 1'b1;
        slp <= s;
        @(posedge clk);
        wdt <= 1'b0;
        slp <= 1'b0;
        #1;
        `CHK({tof, pdf, hold, defr}, {fl, 1'b1, dr})
    endtask : wdt_evt

    initial begin
        rst_n = 1'b0;
        wdt = 1'b0;
        slp = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        cfg = cfg_t'(4'h9);
        err_count = 0;
        total_checks = 0;
        cyc = 0;
        // Power-up timer enabled by its fuse, brown-out on; crystal mode adds start-up
        por(cfg_t'(4'h9), 6150, 6300);
        chk_reg(ADDR_FLAGS, 8'h18);
        chk_reg(ADDR_CONFIG, 8'h09);
        chk_reg(4'hF, 8'h00);
        `CHK({cko_oe, cko}, 2'b00)
        $display("power-on done");
        // Watchdog reset in run: defined class cleared, scratch kept
        wr_reg(ADDR_SCRATCH, 8'h5A);
        wr_reg(ADDR_IRQ_MASK, 8'h3E);
        wr_reg(ADDR_FLAGS, 8'hFF);
        wdt_evt(1'b0, 2'b01, 1'b1);
        wait_hold(0, 3);
        chk_reg(ADDR_FLAGS, 8'h0B);
        chk_reg(ADDR_IRQ_MASK, 8'h00);
        chk_reg(ADDR_SCRATCH, 8'h5A);
        $display("watchdog reset done");
        // Watchdog wake: start-up timer only, mask survives
        wr_reg(ADDR_IRQ_MASK, 8'h3E);
        wdt_evt(1'b1, 2'b00, 1'b0);
        wait_hold(6100, 6250);
        `CHK(wake, 1'b1)
        chk_reg(ADDR_FLAGS, 8'h04);
        chk_reg(ADDR_IRQ_MASK, 8'h3E);
        $display("watchdog wake done");
        // Short glitch on the pin is ignored, a long pulse resets
        supply_osc_model_i.pin_low(20);
        repeat (60) @(posedge clk);
        chk_reg(ADDR_FLAGS, 8'h04);
        supply_osc_model_i.pin_low(60);
        #1;
        `CHK({hold, defr}, 2'b11)
        wait_hold(30, 60);
        chk_reg(ADDR_FLAGS, 8'h01);
        @(posedge clk);
        slp <= 1'b1;
        supply_osc_model_i.pin_low(60);
        wait_hold(30, 60);
        @(posedge clk);
        slp <= 1'b0;
        chk_reg(ADDR_FLAGS, 8'h12);
        $display("reset pin done");
        // Brown-out: long hold, flags kept, no power-on restart
        supply_osc_model_i.supply_dip(2100);
        #1;
        `CHK(hold, 1'b1)
        wait_hold(6150, 8500);
        chk_reg(ADDR_FLAGS, 8'h15);
        chk_reg(ADDR_SCRATCH, 8'h5A);
        $display("brown-out done");
        // Sticky causes, mask and clear by writing one
        chk_reg(ADDR_IRQ_STATUS, 8'h3F);
        chk_reg(ADDR_IRQ_MASK, 8'h00);
        `CHK(irq, 1'b0)
        wr_reg(ADDR_IRQ_MASK, 8'h20);
        @(posedge clk);
        #1;
        `CHK(irq, 1'b1)
        wr_reg(ADDR_IRQ_STATUS, 8'h20);
        @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        chk_reg(ADDR_IRQ_STATUS, 8'h1F);
        $display("interrupt done");
        // RC mode: timer from the RC source only, then none when disabled
        por(cfg_t'(4'h3), 20, 50);
        por(cfg_t'(4'h7), 0, 10);
        k = 0;
        prev = cko;
        repeat (240) begin
            @(posedge clk);
            #1;
            if (cko === 1'b1 && prev === 1'b0) k++;
            prev = cko;
        end
        `CHK({cko_oe, 1'(k >= 9 && k <= 11)}, 2'b11)
        $display("rc mode done");
        end_of_test();
    end
endmodule : reset_and_powerup_sequencer_tb

// ---- reset_seq_pkg.sv ----
// Shared constants and types for the reset and power-up sequencer.
// Assumes a single 20 MHz system clock and static configuration fuses.
package reset_seq_pkg;

    // System clock
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Power-up timer, counted in ticks of the dedicated RC oscillator
    localparam int unsigned POWER_UP_TIMER_MS = 72;
    localparam int unsigned RC_OSC_KHZ = 40;
    localparam int unsigned POWER_UP_TIMER_RC_TICKS = POWER_UP_TIMER_MS * RC_OSC_KHZ;

    // Oscillator start-up timer, in input-oscillator cycles
    localparam int unsigned OST_CYCLES = 1024;

    // Minimum widths honoured by the pin and brown-out filters
    localparam int unsigned EXT_RESET_PIN_N_MIN_NS = 2000;
    localparam int unsigned EXT_RESET_PIN_N_MIN_CYCLES = (EXT_RESET_PIN_N_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BOR_MIN_NS = 100000;
    localparam int unsigned BOR_MIN_CYCLES = (BOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
    localparam logic [3:0] ADDR_SCRATCH = 4'h3;
    localparam logic [3:0] ADDR_CONFIG = 4'h4;

    // Field positions of the flags register
    localparam int unsigned FLAG_TO_BIT = 4;
    localparam int unsigned FLAG_PD_BIT = 3;

    // Reset values
    localparam logic [7:0] IRQ_STATUS_RST = 8'h01;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;

    // Oscillator mode encodings of the configuration fuses
    localparam logic [1:0] OSC_LP = 2'h0;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_RC = 2'h3;

    // Reset causes, also the bit index in the interrupt status register
    localparam logic [2:0] CAUSE_POR = 3'h0;
    localparam logic [2:0] CAUSE_PIN_RUN = 3'h1;
    localparam logic [2:0] CAUSE_PIN_SLEEP = 3'h2;
    localparam logic [2:0] CAUSE_WDT_RST = 3'h3;
    localparam logic [2:0] CAUSE_WDT_WAKE = 3'h4;
    localparam logic [2:0] CAUSE_BOR = 3'h5;

    typedef struct packed {
        logic bor_enable;
        logic power_up_timer_disable;
        logic [1:0] osc_mode;
    } cfg_t;

    typedef struct packed {
        logic timeout;
        logic powerdown;
    } flags_t;

endpackage : reset_seq_pkg

// ---- supply_osc_model.sv ----
// Model of the reset pin, supply detector and both oscillator sources.
// Assumes clk is the system clock; pin and detector move just after its rising edge.
`timescale 1ns/1ns
module supply_osc_model (
    input wire logic clk,
    output logic ext_reset_pin_n,
    output logic brownout_det,
    output logic rc_osc_pin,
    output logic osc_in_pin
);
    // Dedicated RC source, 400 ns period, unrelated to the main clock
    initial begin
        rc_osc_pin = 1'b0;
        forever #200 rc_osc_pin = ~rc_osc_pin;
    end
    // External clock driving the input pin instead of a crystal
    initial begin
        osc_in_pin = 1'b0;
        forever #150 osc_in_pin = ~osc_in_pin;
    end
    // Pin pulled up, supply good at start
    initial begin
        ext_reset_pin_n = 1'b1;
        brownout_det = 1'b0;
    end
    // Low pulse on the reset pin, n clock cycles long
    task automatic pin_low(input int n);
        @(posedge clk);
        ext_reset_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        ext_reset_pin_n <= 1'b1;
    endtask : pin_low
    // Supply dip below the brown-out level for n cycles
    task automatic supply_dip(input int n);
        @(posedge clk);
        brownout_det <= 1'b1;
        repeat (n) @(posedge clk);
        brownout_det <= 1'b0;
    endtask : supply_dip
endmodule : supply_osc_model

// ---- sync_filter.sv ----
// Two-flop synchroniser followed by a minimum-width filter.
// Assumes the raw input is asynchronous to clk.
`timescale 1ns/1ns
module sync_filter #(
    parameter int unsigned MIN_CYCLES = 1,
    parameter bit RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic level
);
    logic meta_r;
    logic sync_r;
    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;
    logic level_nxt;
    wire differs = (sync_r != level);
    wire at_limit = (cnt_r == 12'(MIN_CYCLES - 1));

    // Shorter excursions never reach the output
    assign cnt_nxt = (differs && !at_limit) ? cnt_r + 12'h001 : 12'h000;
    assign level_nxt = (differs && at_limit) ? sync_r : level;

    // Synchroniser; only sync_r reads meta_r
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
            cnt_r <= 12'h000;
            level <= RST_VAL;
        end else begin
            meta_r <= raw;
            sync_r <= meta_r;
            cnt_r <= cnt_nxt;
            level <= level_nxt;
        end
    end
endmodule : sync_filter
